// ### design/window_watchdog_pkg.sv
package window_watchdog_pkg;
  // timebase in ns
  localparam int unsigned CLK_PERIOD_NS   = 4;
  // default factory times (ns) and derived cycle counts
  localparam longint unsigned CLOSE_TIME_NS   = 64'd1_000_000;
  localparam longint unsigned ASSERT_TIME_NS  = 64'd2_000_000;
  localparam longint unsigned STARTUP_TIME_NS = 64'd0;
  localparam int unsigned CLOSE_CYC   = int'(CLOSE_TIME_NS / CLK_PERIOD_NS);
  localparam int unsigned ASSERT_CYC  = int'(ASSERT_TIME_NS / CLK_PERIOD_NS);
  localparam int unsigned STARTUP_CYC = int'(STARTUP_TIME_NS / CLK_PERIOD_NS);
  // bounds on factory settings (ns)
  localparam longint unsigned CLOSE_MIN_NS  = 64'd1_000_000;
  localparam longint unsigned CLOSE_MAX_NS  = 64'd100_000_000_000;
  localparam longint unsigned ASSERT_MIN_NS = 64'd2_000_000;
  localparam longint unsigned ASSERT_MAX_NS = 64'd10_000_000_000;
  localparam longint unsigned STARTUP_MAX_NS = 64'd10_000_000_000;
  localparam int unsigned CNT_W = 36;
  // open-to-closed ratio for ratio_select_1:0 = 00,01,10,11
  localparam logic [8:0] RATIO_SEL0 = 9'h001;
  localparam logic [8:0] RATIO_SEL1 = 9'h007;
  localparam logic [8:0] RATIO_SEL2 = 9'h03f;
  localparam logic [8:0] RATIO_SEL3 = 9'h1ff;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_STARTUP = 3'b001,
    ST_CLOSED  = 3'b011,
    ST_OPEN    = 3'b010,
    ST_FAULT   = 3'b110,
    ST_LATCH   = 3'b111
  } wd_state_t;
endpackage

// ### design/window_watchdog_timer.sv
`timescale 1ns/1ps
// Functional notes
// - fault output is low whenever manual assert input is low
// - a detected watchdog error also drives the fault output low
// - host kicks with falling edge in open window; missing kick faults
// - monitoring runs only while monitor enable is high
// - ratio selects and monitor enable decide ratio and enable
// - open to closed ratio 1x to 511x, changeable while running
// - latched option holds a watchdog fault until it is cleared
// - closed window length configurable from 1 ms to 100 s
// - fault held for assert delay, 2 ms to 10 s
// - optional startup delay before monitoring, zero to 10 s
// - all window and delay times accurate within ten percent
// - fault output is active low, open drain or push pull
module window_watchdog_timer
  import window_watchdog_pkg::*;
#(
  parameter int unsigned CLOSE_CYCLES   = window_watchdog_pkg::CLOSE_CYC,
  parameter int unsigned ASSERT_CYCLES  = window_watchdog_pkg::ASSERT_CYC,
  parameter int unsigned STARTUP_CYCLES = window_watchdog_pkg::STARTUP_CYC,
  parameter bit          LATCHED        = 1'b0,
  parameter bit          OPEN_DRAIN     = 1'b0
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_b,
  // host side pins
  input  wire logic kick_input,
  input  wire logic manual_assert_n,
  input  wire logic monitor_enable,
  input  wire logic ratio_select_0,
  input  wire logic ratio_select_1,
  // latched fault clear
  input  wire logic fault_clear,
  // fault output
  output logic      fault_out_n,
  output logic      fault_oe
);
  import window_watchdog_pkg::*;

  // a count below one would wrap the minus-one load to a huge count
  if (CLOSE_CYCLES < 1 || ASSERT_CYCLES < 1) begin : g_bad_count
    $error("window_watchdog_timer: counts must be at least one");
  end

  // factory defaults, in whole cycles, must land inside the ranges;
  // whole cycles keep them exact, far inside the ten percent budget
  localparam longint unsigned CLOSE_DEF_NS  = 64'(CLOSE_CYC) * CLK_PERIOD_NS;
  localparam longint unsigned ASSERT_DEF_NS = 64'(ASSERT_CYC) * CLK_PERIOD_NS;
  localparam longint unsigned START_DEF_NS  = 64'(STARTUP_CYC) * CLK_PERIOD_NS;

  if (CLOSE_DEF_NS < CLOSE_MIN_NS ||
      CLOSE_DEF_NS > CLOSE_MAX_NS) begin : g_bad_close
    $error("window_watchdog_timer: closed window default out of range");
  end
  if (ASSERT_DEF_NS < ASSERT_MIN_NS ||
      ASSERT_DEF_NS > ASSERT_MAX_NS) begin : g_bad_assert
    $error("window_watchdog_timer: assert delay default out of range");
  end
  if (START_DEF_NS > STARTUP_MAX_NS) begin : g_bad_start
    $error("window_watchdog_timer: startup delay default out of range");
  end

  typedef struct packed {
    wd_state_t        state;
    logic [CNT_W-1:0] cnt;
    logic [8:0]       openLeft;
    logic             kickPrev;
    logic             faultN;
    logic             oe;
  } wd_regs_t;

  wd_regs_t st_reg;
  wd_regs_t st_next;

  logic       kickFall;
  logic [8:0] ratio;
  logic       cntDone;
  logic       wdError;

  // falling edge of kick; pins are synchronous to ref_clk
  assign kickFall = st_reg.kickPrev & ~kick_input;
  assign cntDone  = (st_reg.cnt == '0);

  always_comb begin
    // ratio sampled live: loaded into openLeft as an open window starts; a drop to openLeft or below faults that window
    case ({ratio_select_1, ratio_select_0})
      2'b00:   ratio = RATIO_SEL0;
      2'b01:   ratio = RATIO_SEL1;
      2'b10:   ratio = RATIO_SEL2;
      2'b11:   ratio = RATIO_SEL3;
      default: ratio = RATIO_SEL0;
    endcase
  end

  always_comb begin
    st_next          = st_reg;
    st_next.kickPrev = kick_input;
    wdError          = 1'b0;
    if (!cntDone)
      st_next.cnt = st_reg.cnt - CNT_W'(1);
    case (st_reg.state)
      ST_IDLE: begin
        if (monitor_enable) begin
          st_next.state = ST_STARTUP;
          st_next.cnt   = CNT_W'(STARTUP_CYCLES);
        end
      end
      ST_STARTUP: begin
        if (cntDone) begin
          st_next.state = ST_CLOSED;
          st_next.cnt   = CNT_W'(CLOSE_CYCLES - 1);
        end
      end
      ST_CLOSED: begin
        if (kickFall) begin
          wdError = 1'b1;
        end else if (cntDone) begin
          st_next.state    = ST_OPEN;
          st_next.cnt      = CNT_W'(CLOSE_CYCLES - 1);
          st_next.openLeft = ratio - 9'h001;
        end
      end
      ST_OPEN: begin
        if (kickFall) begin
          st_next.state = ST_CLOSED;
          st_next.cnt   = CNT_W'(CLOSE_CYCLES - 1);
        end else if (cntDone) begin
          if (st_reg.openLeft == 9'h000 || st_reg.openLeft >= ratio) begin
            wdError = 1'b1;
          end else begin
            st_next.openLeft = st_reg.openLeft - 9'h001;
            st_next.cnt      = CNT_W'(CLOSE_CYCLES - 1);
          end
        end
      end
      ST_FAULT: begin
        if (cntDone) begin
          if (LATCHED) begin
            st_next.state = ST_LATCH;
          end else begin
            st_next.state = ST_CLOSED;
            st_next.cnt   = CNT_W'(CLOSE_CYCLES - 1);
          end
        end
      end
      ST_LATCH: begin
        if (fault_clear) begin
          st_next.state = ST_CLOSED;
          st_next.cnt   = CNT_W'(CLOSE_CYCLES - 1);
        end
      end
      default: st_next.state = ST_IDLE;
    endcase
    if (wdError) begin
      st_next.state = ST_FAULT;
      st_next.cnt   = CNT_W'(ASSERT_CYCLES - 1);
    end
    // disable wins over everything but a running or latched fault
    if (!monitor_enable && st_reg.state != ST_LATCH &&
        st_reg.state != ST_FAULT) begin
      st_next.state = ST_IDLE;
      st_next.cnt   = '0;
    end
    st_next.faultN = ~((st_next.state == ST_FAULT) ||
                       (st_next.state == ST_LATCH) ||
                       !manual_assert_n);
    // open drain drives only the low level
    st_next.oe = OPEN_DRAIN ? ~st_next.faultN : 1'b1;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '{state: ST_IDLE, cnt: '0, openLeft: 9'h000,
                  kickPrev: 1'b1, faultN: 1'b1, oe: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign fault_out_n = st_reg.faultN;
  assign fault_oe    = st_reg.oe;

  sequence s_closed_kick;
    st_reg.state == ST_CLOSED && kickFall && monitor_enable;
  endsequence

  AST_MR_ASSERTS: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !manual_assert_n |=> !fault_out_n)
    else $error("manual assert did not drive fault low");

  AST_CLOSED_KICK: assert property (@(posedge ref_clk) disable iff (!rst_b)
    s_closed_kick |=> st_reg.state == ST_FAULT && !fault_out_n)
    else $error("early kick not faulted");

  AST_OPEN_KICK: assert property (@(posedge ref_clk) disable iff (!rst_b)
    st_reg.state == ST_OPEN && kickFall && monitor_enable
    |=> st_reg.state == ST_CLOSED)
    else $error("open window kick not accepted");

  AST_DISABLE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !monitor_enable && st_reg.state inside {ST_CLOSED, ST_OPEN}
    |=> st_reg.state == ST_IDLE)
    else $error("monitoring not disabled");

  AST_FAULT_LOW: assert property (@(posedge ref_clk) disable iff (!rst_b)
    st_reg.state == ST_FAULT |-> !fault_out_n)
    else $error("fault state without low output");

  AST_FAULT_LEN: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $rose(st_reg.state == ST_FAULT) |->
    st_reg.cnt == CNT_W'(ASSERT_CYCLES - 1))
    else $error("assert delay not loaded");

  AST_RELEASE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    st_reg.state == ST_FAULT && cntDone && !LATCHED && monitor_enable
    |=> st_reg.state == ST_CLOSED
        && st_reg.cnt == CNT_W'(CLOSE_CYCLES - 1))
    else $error("no restart after assert delay");

  AST_LATCH_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_b)
    st_reg.state == ST_LATCH && !fault_clear
    |=> st_reg.state == ST_LATCH && !fault_out_n)
    else $error("latched fault released early");

  AST_OPEN_LOAD: assert property (@(posedge ref_clk) disable iff (!rst_b)
    st_reg.state == ST_CLOSED && cntDone && !kickFall && monitor_enable
    |=> st_reg.state == ST_OPEN)
    else $error("open window not entered");

  AST_OE_PP: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !OPEN_DRAIN && $past(rst_b) |-> fault_oe)
    else $error("push pull output not driven");

  sequence s_closed_end;
    st_reg.state == ST_CLOSED && cntDone && !kickFall && monitor_enable;
  endsequence

  sequence s_open_end;
    st_reg.state == ST_OPEN && cntDone && !kickFall && monitor_enable;
  endsequence

  AST_NO_FALSE_FAULT: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    st_reg.state inside {ST_IDLE, ST_STARTUP, ST_CLOSED, ST_OPEN} &&
    $past(rst_b) && $past(manual_assert_n) |-> fault_out_n)
    else $error("fault output low without cause");

  AST_STARTUP_LOAD: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    st_reg.state == ST_IDLE && monitor_enable |=> st_reg.state == ST_STARTUP
    && st_reg.cnt == CNT_W'(STARTUP_CYCLES))
    else $error("startup delay not loaded");

  AST_STARTUP_END: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    st_reg.state == ST_STARTUP && cntDone && monitor_enable
    |=> st_reg.state == ST_CLOSED && st_reg.cnt == CNT_W'(CLOSE_CYCLES - 1))
    else $error("closed window not started after startup");

  AST_OPEN_RATIO: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    s_closed_end |=> st_reg.openLeft == $past(ratio) - 9'h001)
    else $error("open window ratio not loaded");

  AST_OPEN_SEG: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    s_open_end ##0 (st_reg.openLeft != 9'h000 && st_reg.openLeft < ratio)
    |=> st_reg.state == ST_OPEN && st_reg.cnt == CNT_W'(CLOSE_CYCLES - 1))
    else $error("open window segment not reloaded");

  AST_OPEN_MISS: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    s_open_end ##0 st_reg.openLeft == 9'h000
    |=> st_reg.state == ST_FAULT && !fault_out_n)
    else $error("missing kick not faulted");

  AST_IDLE_HOLD: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    st_reg.state == ST_IDLE && !monitor_enable |=> st_reg.state == ST_IDLE)
    else $error("monitoring started while disabled");

  AST_FAULT_STAY: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    st_reg.state == ST_FAULT && !cntDone
    |=> st_reg.state == ST_FAULT && !fault_out_n)
    else $error("fault released before assert delay");

  AST_LATCH_ENTRY: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    st_reg.state == ST_FAULT && cntDone && LATCHED
    |=> st_reg.state == ST_LATCH)
    else $error("latched option did not latch");

  AST_LATCH_CLEAR: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    st_reg.state == ST_LATCH && fault_clear
    |=> st_reg.state == ST_CLOSED && fault_out_n == $past(manual_assert_n))
    else $error("latched fault not cleared");

  AST_OD_OE: assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    OPEN_DRAIN |-> fault_oe == !fault_out_n)
    else $error("open drain enable does not follow low output");
endmodule

// ### verification/host_kicker.sv
`timescale 1ns/1ps
module host_kicker (
  // clock
  input  wire logic ref_clk,
  // request from the bench
  input  wire logic kickReq,
  // kick pin
  output logic      kick_input
);
  initial kick_input = 1'b1;
  // one clean fall per request; the pin idles high between kicks
  always @(posedge ref_clk) begin
    kick_input <= !kickReq;
  end
endmodule

// ### verification/window_watchdog_timer_tb_top.sv
`timescale 1ns/1ps
module window_watchdog_timer_tb_top;
  import window_watchdog_pkg::*;
  // short counts keep the run brief
  localparam int unsigned CL = 8;
  localparam int unsigned AS = 5;
  localparam int unsigned SU = 3;
  logic        ref_clk       = 1'b0;
  logic        rst_b         = 1'b0;
  logic        kickReq       = 1'b0;
  logic        manualAssertN = 1'b1;
  logic        monitorEnable = 1'b0;
  logic [1:0]  ratioSel      = 2'h0;
  logic        quiet         = 1'b0;
  logic [15:0] lfsr          = 16'h5c42;
  logic        kick_input;
  logic        fault_out_n;
  logic        fault_oe;
  logic        fltClear      = 1'b0;
  logic        latchOutN;
  logic        latchOe;
  int          failures      = 0;
  int          tests_run     = 0;
  int          cycles        = 0;

  always #2 ref_clk = ~ref_clk;

  host_kicker host (
    .ref_clk    (ref_clk),
    .kickReq    (kickReq),
    .kick_input (kick_input)
  );

  // first build latches and drives only the low level
  window_watchdog_timer #(
    .CLOSE_CYCLES   (CL),
    .ASSERT_CYCLES  (AS),
    .STARTUP_CYCLES (SU),
    .LATCHED        (1'b1),
    .OPEN_DRAIN     (1'b1)
  ) dutLatch (
    .ref_clk         (ref_clk),
    .rst_b           (rst_b),
    .kick_input      (kick_input),
    .manual_assert_n (manualAssertN),
    .monitor_enable  (monitorEnable),
    .ratio_select_0  (ratioSel[0]),
    .ratio_select_1  (ratioSel[1]),
    .fault_clear     (fltClear),
    .fault_out_n     (latchOutN),
    .fault_oe        (latchOe)
  );

  // latched clear stays tied: this build is the unlatched option
  window_watchdog_timer #(
    .CLOSE_CYCLES   (CL),
    .ASSERT_CYCLES  (AS),
    .STARTUP_CYCLES (SU)
  ) dut (
    .ref_clk         (ref_clk),
    .rst_b           (rst_b),
    .kick_input      (kick_input),
    .manual_assert_n (manualAssertN),
    .monitor_enable  (monitorEnable),
    .ratio_select_0  (ratioSel[0]),
    .ratio_select_1  (ratioSel[1]),
    .fault_clear     (1'b0),
    .fault_out_n     (fault_out_n),
    .fault_oe        (fault_oe)
  );

  function automatic logic [15:0] nextRand(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  function automatic int ratioOf(logic [1:0] s);
    case (s)
      2'h0: return int'(RATIO_SEL0);
      2'h1: return int'(RATIO_SEL1);
      2'h2: return int'(RATIO_SEL2);
      default: return int'(RATIO_SEL3);
    endcase
  endfunction

  task automatic step(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic check(string name, logic exp, logic seen);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %b seen %b", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // a one-cycle request; the partner turns it into a falling edge
  task automatic kickAfter(int n);
    step(n);
    kickReq = 1'b1;
    step(1);
    kickReq = 1'b0;
  endtask

  // sampled mid-cycle, away from the edge that launches the output
  always @(negedge ref_clk) begin
    if (quiet) check("quietOut", 1'b1, fault_out_n);
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 60000) begin
      failures++;
      tally_and_finish();
    end
  end

  initial begin
    int off;
    int cnt;
    step(2);
    rst_b = 1'b1;
    step(2);
    manualAssertN = 1'b0;
    step(2);
    check("manualLow", 1'b0, fault_out_n);
    check("pushPullOe", 1'b1, fault_oe);
    manualAssertN = 1'b1;
    step(2);
    check("manualHigh", 1'b1, fault_out_n);
    // disabled, then kicked inside the open window: must stay quiet
    quiet = 1'b1;
    step(200);
    for (int r = 0; r < 4; r++) begin
      ratioSel = 2'(r);
      monitorEnable = 1'b1;
      for (int k = 0; k < 3; k++) begin
        lfsr = nextRand(lfsr);
        off = 2 + int'(lfsr) % (ratioOf(ratioSel) * CL - 4);
        kickAfter((k == 0 ? SU : 0) + CL + off);
      end
      monitorEnable = 1'b0;
      step(2);
    end
    ratioSel = 2'h0;
    quiet = 1'b0;
    monitorEnable = 1'b1;
    cnt = 0;
    while (fault_out_n === 1'b1 && cnt < 60) begin
      step(1);
      cnt++;
    end
    check("missTime", 1'b1, cnt >= SU + 2*CL - 2 && cnt <= SU + 2*CL + 6);
    cnt = 0;
    while (fault_out_n === 1'b0 && cnt < 60) begin
      step(1);
      cnt++;
    end
    check("assertLen", 1'b1, cnt == AS);
    // after release a fresh closed window runs, then open
    quiet = 1'b1;
    kickAfter(CL + 2);
    quiet = 1'b0;
    kickAfter(1);
    cnt = 0;
    while (fault_out_n === 1'b1 && cnt < 20) begin
      step(1);
      cnt++;
    end
    check("closedKick", 1'b1, cnt < 8);
    check("latchHeld", 1'b0, latchOutN);
    check("latchOe", 1'b1, latchOe);
    fltClear = 1'b1;
    step(1);
    fltClear = 1'b0;
    check("latchClear", 1'b1, latchOutN);
    check("latchOeOff", 1'b0, latchOe);
    tally_and_finish();
  end
endmodule
